// >>> hdl/pmx_port.sv
// parallel master port: pin ownership, strobes, widths and address muxing
//
// Functional notes
// RL1: set pin enable gives pin its port function; clear returns it to gpio.
// RL2: enabled address pin drives matching bit of the target address.
// RL3: enable bits of address pins zero and one gate the latch strobes.
// RL4: software should enable latch strobe pins when choosing a muxed mode.
// RL5: master mode 1 uses direction line plus separate enable strobe.
// RL6: master mode 2 uses separate read and write strobes.
// RL7: each control output has its own polarity select; here both latch strobes share pol_addr_latch.
// RL8: write strobe and enable strobe share one polarity bit.
// RL9: wide data select chooses 8 or 16 bit transfers.
// RL10: 16-bit transfer sends low byte first, byte enable on high byte.
// RL11: in master modes the mux field picks the address scheme.
// RL12: mux 00 keeps address on pins, data alone on data lines.
// RL13: mux 01 puts low address on data lines, pin zero latches.
// RL14: partial mux adds one cycle carrying the address byte.
// RL15: mux 10 puts all address on data lines, pins zero and one latch.
// RL16: full mux adds low-address cycle then high-address cycle.
// RL17: address bits used as chip select are presented as zero.
// RL18: master operation needs port enable and mode field 10 or 11.
// RL19: chip select holds through latch cycles and data, drops after.
`timescale 1ns/1ps
`default_nettype none
module pmx_port
  import pmx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire logic port_enable_bit,
  input wire logic [1:0] port_mode,
  input wire logic wide_data_select,
  input wire logic [1:0] address_mux_select,
  input wire logic chip_select_on,
  input wire logic pol_read,
  input wire logic pol_write_enable,
  input wire logic pol_byte_enable,
  input wire logic pol_addr_latch,
  input wire logic pol_chip_select,
  input wire logic byte_enable_pin_on,
  input wire logic write_strobe_pin_on,
  input wire logic read_strobe_pin_on,
  input wire logic [ADDR_W-1:0] address_pin_on,
  // request stream
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_data,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic busy,
  // general purpose fallback values
  input wire logic [ADDR_W-1:0] gpio_addr_out,
  input wire logic [ADDR_W-1:0] gpio_addr_oe_n,
  input wire logic [2:0] gpio_ctl_out,
  input wire logic [2:0] gpio_ctl_oe_n,
  // pins
  output logic [ADDR_W-1:0] addr_pin_out,
  output logic [ADDR_W-1:0] addr_pin_oe_n,
  output logic read_strobe,
  output logic read_strobe_oe_n,
  output logic write_strobe,
  output logic write_strobe_oe_n,
  output logic byte_enable_strobe,
  output logic byte_enable_strobe_oe_n,
  input wire logic [BUS_W-1:0] parallel_data_in,
  output logic [BUS_W-1:0] parallel_data_out,
  output logic parallel_data_oe_n
);

  localparam logic [2:0] LAST_CYC = 3'(STROBE_CYC - 1);

  // ----------------------------------------------------------------
  // request queue
  // ----------------------------------------------------------------
  logic fifo_valid;
  logic fifo_pop;
  logic [REQ_W-1:0] fifo_data;

  pmx_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_write, req_addr, req_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // data input synchroniser
  // ----------------------------------------------------------------
  logic [BUS_W-1:0] din_s1_q;
  logic [BUS_W-1:0] din_s2_q;
  logic [BUS_W-1:0] din_s3_q;
  logic [BUS_W-1:0] din_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      din_s1_q <= BUS_ZERO;
      din_s2_q <= BUS_ZERO;
      din_s3_q <= BUS_ZERO;
      din_q <= BUS_ZERO;
    end
    else
    begin
      din_s1_q <= parallel_data_in;
      din_s2_q <= din_s1_q;
      din_s3_q <= din_s2_q;
      // a change counts only once two stages agree
      if (din_s2_q == din_s3_q)
      begin
        din_q <= din_s3_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  pmx_state_e state_q;
  pmx_state_e state_d;
  logic [2:0] cnt_q;
  logic master;
  logic mux_part;
  logic mux_full;
  logic mode1;
  logic phase_done;

  // RL18: master gate
  assign master = port_enable_bit && port_mode[MODE_MASTER_BIT];
  // RL11: mux scheme pick
  assign mux_part = (address_mux_select == MUX_PART);
  assign mux_full = (address_mux_select == MUX_FULL);
  assign mode1 = (port_mode == MODE_MASTER1);
  assign phase_done = (cnt_q == LAST_CYC);
  assign fifo_pop = !busy && master && fifo_valid;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PMX_IDLE:
      begin
        if (fifo_pop)
        begin
          state_d = PMX_LOAD;
        end
      end
      PMX_LOAD:
      begin
        // RL14: partial mux extra cycle
        // RL16: full mux two extra cycles
        if (mux_part || mux_full)
        begin
          state_d = PMX_LATCH_LO;
        end
        else
        begin
          state_d = PMX_DATA_LO;
        end
      end
      PMX_LATCH_LO:
      begin
        state_d = mux_full ? PMX_LATCH_HI : PMX_DATA_LO;
      end
      PMX_LATCH_HI:
      begin
        state_d = PMX_DATA_LO;
      end
      PMX_DATA_LO:
      begin
        // RL9: width select
        if (phase_done)
        begin
          state_d = wide_data_select ? PMX_DATA_HI : PMX_IDLE;
        end
      end
      PMX_DATA_HI:
      begin
        if (phase_done)
        begin
          state_d = PMX_IDLE;
        end
      end
      default:
      begin
        state_d = PMX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= PMX_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // cycles spent inside one data phase
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
    end
    else if (state_d != state_q)
    begin
      cnt_q <= '0;
    end
    else if (!phase_done)
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // current transfer
  // ----------------------------------------------------------------
  logic xfer_wr_q;
  logic [ADDR_W-1:0] xfer_addr_q;
  logic [DATA_W-1:0] xfer_data_q;
  logic [ADDR_W-1:0] addr_eff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      xfer_wr_q <= 1'b0;
      xfer_addr_q <= '0;
      xfer_data_q <= '0;
    end
    else if (state_q == PMX_LOAD)
    begin
      xfer_wr_q <= fifo_data[REQ_WR_BIT];
      xfer_addr_q <= fifo_data[REQ_ADDR_LSB +: ADDR_W];
      xfer_data_q <= fifo_data[DATA_W-1:0];
    end
  end

  // RL17: chip select bit zeroed
  always_comb
  begin
    addr_eff = xfer_addr_q;
    if (chip_select_on)
    begin
      addr_eff[PIN_CHIP_SEL] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data capture
  // ----------------------------------------------------------------
  logic [BUS_W-1:0] rd_lo_q;
  logic [1:0] cap_lo_q;
  logic [1:0] cap_hi_q;

  // the synchroniser trails the pins by four edges, so each byte is
  // taken two edges after its phase ends, while it still stands
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_lo_q <= BUS_ZERO;
      rd_data <= '0;
      rd_valid <= 1'b0;
      cap_lo_q <= 2'h0;
      cap_hi_q <= 2'h0;
    end
    else
    begin
      rd_valid <= 1'b0;
      cap_lo_q <= {cap_lo_q[0], !xfer_wr_q && phase_done
                   && state_q == PMX_DATA_LO};
      cap_hi_q <= {cap_hi_q[0], !xfer_wr_q && phase_done
                   && state_q == PMX_DATA_HI};
      if (cap_lo_q[1])
      begin
        rd_lo_q <= din_q;
        if (!wide_data_select)
        begin
          rd_data <= {BUS_ZERO, din_q};
          rd_valid <= 1'b1;
        end
      end
      // RL10: high byte second
      if (cap_hi_q[1])
      begin
        rd_data <= {din_q, rd_lo_q};
        rd_valid <= 1'b1;
      end
    end
  end

  // a pending capture keeps the next transfer back
  assign busy = (state_q != PMX_IDLE) || (|cap_lo_q) || (|cap_hi_q);

  // ----------------------------------------------------------------
  // strobe activity and polarity
  // ----------------------------------------------------------------
  logic data_ph;
  logic act_cs;
  logic act_rd;
  logic act_wr;
  logic lvl_rd;
  logic lvl_wr;
  logic lvl_be;
  logic lvl_all;
  logic lvl_alh;
  logic lvl_cs;

  assign data_ph = (state_q == PMX_DATA_LO) || (state_q == PMX_DATA_HI);
  // RL19: select spans latch and data
  assign act_cs = data_ph || (state_q == PMX_LATCH_LO)
                  || (state_q == PMX_LATCH_HI);

  always_comb
  begin
    if (mode1)
    begin
      // RL5: direction plus enable
      act_rd = act_cs && !xfer_wr_q;
      act_wr = data_ph;
    end
    else
    begin
      // RL6: separate strobes
      act_rd = data_ph && !xfer_wr_q;
      act_wr = data_ph && xfer_wr_q;
    end
  end

  // RL7: per-signal polarity
  // RL8: shared write/enable polarity
  assign lvl_rd = pol_read ? act_rd : !act_rd;
  assign lvl_wr = pol_write_enable ? act_wr : !act_wr;
  assign lvl_be = pol_byte_enable
                  ? (state_q == PMX_DATA_HI) : (state_q != PMX_DATA_HI);
  assign lvl_all = pol_addr_latch
                   ? (state_q == PMX_LATCH_LO) : (state_q != PMX_LATCH_LO);
  assign lvl_alh = pol_addr_latch
                   ? (state_q == PMX_LATCH_HI) : (state_q != PMX_LATCH_HI);
  assign lvl_cs = pol_chip_select ? act_cs : !act_cs;

  // ----------------------------------------------------------------
  // address pins
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] apin_d;
  logic [ADDR_W-1:0] apin_oe_n_d;

  for (genvar i = 0; i < ADDR_W; i++)
  begin : g_apin
    always_comb
    begin
      if (!address_pin_on[i])
      begin
        // RL1: address pin fallback
        apin_d[i] = gpio_addr_out[i];
        apin_oe_n_d[i] = gpio_addr_oe_n[i];
      end
      else
      begin
        apin_oe_n_d[i] = 1'b0;
        // RL3: pin enable gates latch strobes
        // RL13: pin zero latch
        // RL15: pins zero and one latch
        if (i == PIN_LATCH_LO && (mux_part || mux_full))
        begin
          apin_d[i] = lvl_all;
        end
        else if (i == PIN_LATCH_HI && mux_full)
        begin
          apin_d[i] = lvl_alh;
        end
        else if (i == PIN_CHIP_SEL && chip_select_on)
        begin
          apin_d[i] = lvl_cs;
        end
        else
        begin
          // RL2: address bit driven
          // RL12: dedicated address pins
          apin_d[i] = addr_eff[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // data lines
  // ----------------------------------------------------------------
  logic [BUS_W-1:0] dout_d;
  logic doe_n_d;

  always_comb
  begin
    dout_d = BUS_ZERO;
    doe_n_d = 1'b1;
    case (state_q)
      PMX_LATCH_LO:
      begin
        // RL13: low address on data lines
        dout_d = addr_eff[BUS_W-1:0];
        doe_n_d = 1'b0;
      end
      PMX_LATCH_HI:
      begin
        // RL16: high address on data lines
        dout_d = addr_eff[ADDR_W-1:BUS_W];
        doe_n_d = 1'b0;
      end
      PMX_DATA_LO:
      begin
        // RL10: low byte first
        dout_d = xfer_data_q[BUS_W-1:0];
        doe_n_d = !xfer_wr_q;
      end
      PMX_DATA_HI:
      begin
        dout_d = xfer_data_q[DATA_W-1:BUS_W];
        doe_n_d = !xfer_wr_q;
      end
      default:
      begin
        dout_d = BUS_ZERO;
        doe_n_d = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // pin registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_pin_out <= '0;
      addr_pin_oe_n <= '1;
      parallel_data_out <= BUS_ZERO;
      parallel_data_oe_n <= 1'b1;
    end
    else
    begin
      addr_pin_out <= apin_d;
      addr_pin_oe_n <= apin_oe_n_d;
      parallel_data_out <= dout_d;
      parallel_data_oe_n <= doe_n_d;
    end
  end

  // RL1: control pins fallback
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      read_strobe <= 1'b0;
      read_strobe_oe_n <= 1'b1;
      write_strobe <= 1'b0;
      write_strobe_oe_n <= 1'b1;
      byte_enable_strobe <= 1'b0;
      byte_enable_strobe_oe_n <= 1'b1;
    end
    else
    begin
      read_strobe <= read_strobe_pin_on ? lvl_rd : gpio_ctl_out[0];
      read_strobe_oe_n <= read_strobe_pin_on ? 1'b0 : gpio_ctl_oe_n[0];
      write_strobe <= write_strobe_pin_on ? lvl_wr : gpio_ctl_out[1];
      write_strobe_oe_n <= write_strobe_pin_on ? 1'b0 : gpio_ctl_oe_n[1];
      byte_enable_strobe <= byte_enable_pin_on ? lvl_be : gpio_ctl_out[2];
      byte_enable_strobe_oe_n <= byte_enable_pin_on
                                 ? 1'b0 : gpio_ctl_oe_n[2];
    end
  end

endmodule // pmx_port
`default_nettype wire

// >>> include/pmx_pkg.sv
// constants and types shared by the parallel master port files
package pmx_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int STROBE_NS = 160;
  // least time, rounded up to whole cycles
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // mode field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_MASTER1 = 2'h3;
  localparam logic [1:0] MODE_MASTER2 = 2'h2;
  localparam int MODE_MASTER_BIT = 1;
  localparam logic [1:0] MUX_NONE = 2'h0;
  localparam logic [1:0] MUX_PART = 2'h1;
  localparam logic [1:0] MUX_FULL = 2'h2;

  // ----------------------------------------------------------------
  // pin positions
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BUS_W = 8;
  localparam int PIN_LATCH_LO = 0;
  localparam int PIN_LATCH_HI = 1;
  localparam int PIN_CHIP_SEL = 14;

  // ----------------------------------------------------------------
  // request queue layout: {write, address, data}
  // ----------------------------------------------------------------
  localparam int REQ_W = 1 + ADDR_W + DATA_W;
  localparam int REQ_WR_BIT = ADDR_W + DATA_W;
  localparam int REQ_ADDR_LSB = DATA_W;
  localparam int FIFO_DEPTH = 16;
  localparam logic [BUS_W-1:0] BUS_ZERO = 8'h00;

  typedef enum logic [2:0] {
    PMX_IDLE,
    PMX_LOAD,
    PMX_LATCH_LO,
    PMX_LATCH_HI,
    PMX_DATA_LO,
    PMX_DATA_HI
  } pmx_state_e;

endpackage

// >>> hdl/pmx_mem.sv
// small two-port storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module pmx_mem
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
)
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // no reset: contents are only read after being written
  always_ff @(posedge clk)
  begin
    if (rd_en)
    begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule // pmx_mem
`default_nettype wire

// >>> hdl/pmx_fifo.sv
// request queue; popped word appears on out_data one cycle after the pop
`timescale 1ns/1ps
`default_nettype none
module pmx_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  // honest flags from full-width pointers
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign in_ready = (wr_ptr_q[AW-1:0] != rd_ptr_q[AW-1:0])
                    || (wr_ptr_q[AW] == rd_ptr_q[AW]);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  pmx_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .clk(clk),
    .wr_en(push),
    .wr_addr(wr_ptr_q[AW-1:0]),
    .wr_data(in_data),
    .rd_en(pop),
    .rd_addr(rd_ptr_q[AW-1:0]),
    .rd_data(out_data)
  );

endmodule // pmx_fifo
`default_nettype wire

// >>> test/pmx_port_properties.sv
// concurrent checks on the parallel master port pins
`timescale 1ns/1ps
`default_nettype none
module pmx_props
  import pmx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic port_enable_bit,
  input wire logic [1:0] port_mode,
  input wire logic wide_data_select,
  input wire logic [1:0] address_mux_select,
  input wire logic chip_select_on,
  input wire logic pol_read,
  input wire logic pol_write_enable,
  input wire logic pol_byte_enable,
  input wire logic pol_addr_latch,
  input wire logic pol_chip_select,
  input wire logic byte_enable_pin_on,
  input wire logic [ADDR_W-1:0] address_pin_on,
  input wire logic [ADDR_W-1:0] gpio_addr_out,
  input wire logic [ADDR_W-1:0] gpio_addr_oe_n,
  input wire logic busy,
  input wire logic rd_valid,
  input wire logic [ADDR_W-1:0] addr_pin_out,
  input wire logic [ADDR_W-1:0] addr_pin_oe_n,
  input wire logic read_strobe,
  input wire logic read_strobe_oe_n,
  input wire logic write_strobe,
  input wire logic write_strobe_oe_n,
  input wire logic byte_enable_strobe,
  input wire logic parallel_data_oe_n
);
  // ----------------------------------------------------------------
  // active levels and settled configuration
  // ----------------------------------------------------------------
  wire rd_a = read_strobe == pol_read && !read_strobe_oe_n;
  wire wr_a = write_strobe == pol_write_enable && !write_strobe_oe_n;
  wire m2 = port_mode == MODE_MASTER2;
  wire muxed = address_mux_select inside {MUX_PART, MUX_FULL};
  wire lo_a = muxed && addr_pin_out[0] == pol_addr_latch;
  wire hi_a = address_mux_select == MUX_FULL && addr_pin_out[1] == pol_addr_latch;
  wire cs_a = chip_select_on && addr_pin_out[14] == pol_chip_select;
  // pins lag the config by one edge, so only a settled config is judged
  wire [15:0] cfg = {rst_n, port_enable_bit, port_mode, wide_data_select,
    address_mux_select, pol_read, pol_write_enable, pol_byte_enable,
    pol_addr_latch, pol_chip_select, chip_select_on, byte_enable_pin_on,
    address_pin_on[1:0]};
  logic [15:0] cfg_q;
  wire steady = cfg_q == cfg;
  always_ff @(posedge clk) cfg_q <= cfg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_gpio_return: assert property (
    !address_pin_on[5] |=> addr_pin_out[5] == $past(gpio_addr_out[5])
    && addr_pin_oe_n[5] == $past(gpio_addr_oe_n[5])) else $error("gpio lost");
  a_pin_driven: assert property (
    address_pin_on[9] |=> !addr_pin_oe_n[9]) else $error("pin not driven");
  a_master_only: assert property (
    steady && !busy && !(port_enable_bit && port_mode[MODE_MASTER_BIT])
    |=> !busy) else $error("transfer without master mode");
  a_read_release: assert property (
    steady && rd_a && (m2 || wr_a) |-> parallel_data_oe_n)
    else $error("bus driven during read");
  a_write_drive: assert property (
    steady && m2 && wr_a |-> !parallel_data_oe_n && !rd_a)
    else $error("write strobe without bus drive");
  a_narrow_no_be: assert property (
    steady && !wide_data_select && byte_enable_pin_on
    |-> byte_enable_strobe != pol_byte_enable) else $error("byte enable");
  a_latch_in_cs: assert property (
    steady && lo_a && chip_select_on && address_pin_on[PIN_CHIP_SEL]
    |-> cs_a) else $error("latch outside chip select");
  a_latch_pulse: assert property (
    steady && lo_a |=> !lo_a) else $error("latch low too long");
  a_hi_after_lo: assert property (
    steady && hi_a |-> $past(lo_a) && !lo_a) else $error("latch order");
  a_cs_release: assert property (
    steady && $fell(cs_a) |-> parallel_data_oe_n && !wr_a)
    else $error("bus active after chip select");
  a_rd_pulse: assert property (
    rd_valid |-> !busy ##1 !rd_valid) else $error("read pulse");
endmodule // pmx_props
bind pmx_port pmx_props pmx_props_i (.*);
`default_nettype wire

// >>> test/pmx_partner.sv
// behavioural external memory seen through the port's strobes
`timescale 1ns/1ps
`default_nettype none
module pmx_partner
(
  input wire logic clk,
  input wire logic rd_act,
  input wire logic wr_act,
  input wire logic be_act,
  input wire logic [7:0] dout,
  input wire logic [15:0] rd_word,
  output logic [7:0] din,
  output logic [15:0] wr_word
);
  // ----------------------------------------------------------------
  // bus drive and capture
  // ----------------------------------------------------------------
  logic [7:0] last_q = 8'h5a;
  // released bus shows the inverse of the last byte, so stale data fails
  assign din = rd_act ? (be_act ? rd_word[15:8] : rd_word[7:0]) : ~last_q;
  always @(posedge clk)
  begin
    if (rd_act) last_q <= din;
    if (wr_act && be_act) wr_word[15:8] <= dout;
    if (wr_act && !be_act) wr_word[7:0] <= dout;
  end
endmodule // pmx_partner
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the parallel master port
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pmx_pkg::*;
;
  logic clk = 1'h0, rst_n = 1'h0, port_enable_bit = 1'h0, busy, rd_valid;
  logic wide_data_select = 1'h0, chip_select_on = 1'h0, req_ready;
  logic [1:0] port_mode = 2'h0, address_mux_select = 2'h0;
  logic pol_read = 1'h1, pol_write_enable = 1'h1, pol_byte_enable = 1'h1;
  logic pol_addr_latch = 1'h1, pol_chip_select = 1'h1, req_valid = 1'h0;
  logic byte_enable_pin_on = 1'h0, write_strobe_pin_on = 1'h0;
  logic read_strobe_pin_on = 1'h0, req_write = 1'h0, read_strobe;
  logic [15:0] address_pin_on = 16'h0000, req_addr = 16'h0000;
  logic [15:0] req_data = 16'h0000, gpio_addr_out = 16'ha5c3;
  logic [15:0] gpio_addr_oe_n = 16'h0ff0, rd_word = 16'h0000;
  logic [2:0] gpio_ctl_out = 3'h5, gpio_ctl_oe_n = 3'h2;
  logic read_strobe_oe_n, write_strobe, write_strobe_oe_n;
  logic byte_enable_strobe, byte_enable_strobe_oe_n, parallel_data_oe_n;
  logic [15:0] rd_data, addr_pin_out, addr_pin_oe_n, wr_word;
  logic [7:0] parallel_data_in, parallel_data_out, lo_b, hi_b;
  int err_count = 0, checked = 0, rd_n = 0, lo_n = 0, hi_n = 0;
  // ----------------------------------------------------------------
  // pin decoding, design and far side
  // ----------------------------------------------------------------
  wire rd_pin = read_strobe == pol_read && !read_strobe_oe_n;
  wire wr_pin = write_strobe == pol_write_enable && !write_strobe_oe_n;
  wire m1 = port_mode == MODE_MASTER1;
  wire rd_act = rd_pin && (!m1 || wr_pin);
  wire wr_act = wr_pin && !(m1 && rd_pin);
  wire be_act = byte_enable_strobe == pol_byte_enable;
  wire lat_lo = address_mux_select != MUX_NONE && addr_pin_out[0] == pol_addr_latch;
  wire lat_hi = address_mux_select == MUX_FULL && addr_pin_out[1] == pol_addr_latch;
  pmx_port pmx_port_i (.*);
  pmx_partner pmx_partner_i (.clk(clk), .rd_act(rd_act), .wr_act(wr_act),
    .be_act(be_act), .dout(parallel_data_out), .rd_word(rd_word),
    .din(parallel_data_in), .wr_word(wr_word));
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    rd_n += int'(rd_valid === 1'h1);
    lo_n += int'(lat_lo === 1'h1);
    hi_n += int'(lat_hi === 1'h1);
    if (lat_lo === 1'h1) lo_b = parallel_data_out;
    if (lat_hi === 1'h1) hi_b = parallel_data_out;
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cfg(input logic [1:0] m, x, input logic w, p, c);
    @(negedge clk);
    {port_enable_bit, port_mode, address_mux_select} = {1'h1, m, x};
    {wide_data_select, chip_select_on} = {w, c};
    {pol_read, pol_write_enable, pol_byte_enable} = {3{p}};
    {pol_addr_latch, pol_chip_select} = {2{p}};
    // latch strobe pins enabled along with every other pin
    {byte_enable_pin_on, write_strobe_pin_on, read_strobe_pin_on} = 3'h7;
    address_pin_on = 16'hffff;
    repeat (3) @(negedge clk);
    {lo_n, hi_n} = {0, 0};
  endtask
  task automatic push(input logic w, input logic [15:0] a, d);
    @(negedge clk);
    {req_valid, req_write, req_addr, req_data} = {1'h1, w, a, d};
    while (req_ready !== 1'h1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'h0;
  endtask
  task automatic wait_idle;
    repeat (3) @(negedge clk);
    for (int n = 0; n < 99 && busy !== 1'h0; n++) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset;
    chk("gpio addr", addr_pin_out, gpio_addr_out);
    chk("gpio oe", addr_pin_oe_n, gpio_addr_oe_n);
    chk("gpio read pin", read_strobe, gpio_ctl_out[0]);
    chk("gpio write oe", write_strobe_oe_n, gpio_ctl_oe_n[1]);
    address_pin_on = 16'h00ff;
    repeat (2) @(negedge clk);
    chk("pin owner", addr_pin_oe_n, 16'h0f00);
    $display("test reset done");
  endtask
  task automatic t_write(input logic [1:0] m, input logic p,
    input logic [15:0] d);
    cfg(m, MUX_NONE, 1'h1, p, 1'h0);
    push(1'h1, 16'h3c5a, d);
    for (int n = 0; n < 40 && wr_act !== 1'h1; n++) @(negedge clk);
    chk("address pins", addr_pin_out, 16'h3c5a);
    chk("bus low byte", parallel_data_out, d[7:0]);
    wait_idle;
    chk("written word", wr_word, d);
    $display("test write done");
  endtask
  task automatic t_read(input logic [1:0] m, x, input logic w,
    input logic [15:0] a, rw, ex, input int ln, hn);
    int r0;
    cfg(m, x, w, 1'h1, 1'h1);
    {rd_word, r0} = {rw, rd_n};
    push(1'h0, a, 16'h0000);
    wait_idle;
    chk("read data", rd_data, ex);
    chk("read pulses", 16'(rd_n - r0), 16'h0001);
    chk("latch lo count", 16'(lo_n), 16'(ln));
    chk("latch hi count", 16'(hi_n), 16'(hn));
    chk("address on bus", {hi_b, lo_b}, a & 16'hbfff);
    $display("test read done");
  endtask
  task automatic t_queue;
    int r0;
    cfg(2'h1, MUX_NONE, 1'h0, 1'h1, 1'h0);
    {req_valid, req_write, r0} = {1'h1, 1'h0, rd_n};
    repeat (FIFO_DEPTH) @(negedge clk);
    chk("queue full", req_ready, 1'h0);
    req_valid = 1'h0;
    repeat (20) @(negedge clk);
    chk("no master", busy, 1'h0);
    port_mode = MODE_MASTER2;
    for (int n = 0; n < 900 && rd_n != r0 + FIFO_DEPTH; n++) @(negedge clk);
    chk("drained", 16'(rd_n - r0), 16'(FIFO_DEPTH));
    chk("queue room", req_ready, 1'h1);
    $display("test queue done");
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    t_reset;
    t_write(MODE_MASTER2, 1'h1, 16'hbeef);
    t_write(MODE_MASTER1, 1'h0, 16'h1234);
    t_read(MODE_MASTER2, MUX_FULL, 1'h1, 16'h7a12, 16'hc3a5, 16'hc3a5, 1, 1);
    t_read(MODE_MASTER1, MUX_PART, 1'h0, 16'h3a55, 16'h9966, 16'h0066, 1, 0);
    t_queue;
    test_done;
  end
  // watchdog: whole run needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clk);
    err_count++;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
